/* File: cma_pkg.sv */
// Shared constants and types for the macrocell array of the general logic array.
// Assumes one clock domain; the product-term array, the address decode and the
// port registers live outside and arrive here as plain signals.
package cma_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Sizes
  localparam int CMA_GROUP_CELLS = 8;   // Output cells in each group
  localparam int CMA_NUM_OCELLS  = 16;  // Output cells, two groups
  localparam int CMA_NUM_ICELLS  = 24;  // Input cells, ports A, B and C
  localparam int CMA_PT_SLOT     = 4;   // Term slots per cell, widest group

  ////////////////////////////////////////////////////////////////////////////////
  // Product-term allocation limits
  localparam logic [3:0] CMA_NATIVE_AB    = 4'h7;   // Three native terms
  localparam logic [3:0] CMA_NATIVE_BC    = 4'hf;   // Four native terms
  localparam logic [7:0] CMA_BORROW_AB    = 8'h77;  // Up to six borrowed terms
  localparam logic [7:0] CMA_BORROW_BC_LO = 8'h1f;  // Cells 0-3: up to five
  localparam logic [7:0] CMA_BORROW_BC_HI = 8'h3f;  // Cells 4-7: up to six

  ////////////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [7:0] CMA_MASK_RESET = 8'h00;  // All cells accept host loads
  localparam logic [7:0] CMA_DATA_RESET = 8'h00;

  ////////////////////////////////////////////////////////////////////////////////
  // Modes and host targets
  typedef enum logic [1:0] {CMA_FF_D, CMA_FF_T, CMA_FF_JK, CMA_FF_SR} cma_ff_e;
  typedef enum logic [1:0] {CMA_IMC_LATCH, CMA_IMC_REG, CMA_IMC_PASS} cma_imc_e;
  typedef enum logic [2:0] {CMA_TGT_CELLS_AB, CMA_TGT_CELLS_BC, CMA_TGT_MASK_AB,
                            CMA_TGT_MASK_BC, CMA_TGT_IMC_A, CMA_TGT_IMC_B,
                            CMA_TGT_IMC_C} cma_target_e;

endpackage

/* File: cma_macrocell_array.sv */
// Output and input macrocells of the general logic array with host load/read path.
// Assumes the product terms, the config select decode and strobes are synchronous
// to clk; every cell clock is an edge detected on a sampled select.
//
// Overview of operation
// [RULE1] Host loads sixteen output cells, bit n
// [RULE2] Group AB: three native, six borrowed terms
// [RULE3] Group BC: four native, five/six borrowed
// [RULE4] Donor term granted to one cell only
// [RULE5] XOR polarity, register/combinational mux, pin, feedback
// [RULE6] Flip-flop acts as D, T, JK, SR
// [RULE7] Clock from term or external input, rising
// [RULE8] Preset/clear active high, clear two terms
// [RULE9] Host load overrides preset, clear, clock
// [RULE10] Load on trailing strobe edge or level
// [RULE11] Mask bit one blocks host cell write
// [RULE12] Both masks reset to zero
// [RULE13] Pin enable is term OR direction bit
// [RULE14] Output without enable equation drives always
// [RULE15] Internal node never drives pin, keeps feedback
// [RULE16] Twenty-four input cells: latch, register, pass
// [RULE17] Input cell enable: term or address strobe
// [RULE18] One term per nibble of each port
// [RULE19] Host reads input cells through read buffer
// [RULE20] Address strobe captures high address bits
// [RULE21] Mailbox: host writes out, reads input cells
// [RULE22] Host reads group flip-flops on bits 0-7
`timescale 1ns/100ps

module cma_macrocell_array
  import cma_pkg::*;
#(
  parameter int GROUP_CELLS = CMA_GROUP_CELLS
)
(
  // Clock and reset
  input  wire logic                       clk,
  input  wire logic                       rst_b,
  // Host access, already decoded from the config register select
  input  wire logic                       host_wr_b,
  input  wire logic                       host_rd_b,
  input  wire logic [2:0]                 host_target,
  input  wire logic [7:0]                 host_wdata,
  output logic      [7:0]                 host_rdata,
  // Cell configuration
  input  wire logic                       cfg_level_load,
  input  wire logic [15:0][1:0]           cfg_ff_type,
  input  wire logic [15:0]                cfg_invert,
  input  wire logic [15:0]                cfg_comb,
  input  wire logic [15:0]                cfg_ext_clk,
  input  wire logic [15:0]                cfg_internal,
  input  wire logic [15:0]                cfg_no_oe_eq,
  input  wire logic [15:0][3:0]           cfg_pt_own,
  input  wire logic [15:0][7:0]           cfg_pt_borrow,
  // Product terms from the AND array
  input  wire logic [15:0][3:0]           pt_term,
  input  wire logic [15:0]                pt_aux,
  input  wire logic [15:0]                pt_clk,
  input  wire logic [15:0]                pt_preset,
  input  wire logic [15:0]                pt_clear0,
  input  wire logic [15:0]                pt_clear1,
  input  wire logic [15:0]                pt_oe,
  input  wire logic [15:0]                port_dir,
  input  wire logic                       external_clock_input,
  // Input cells
  input  wire logic [23:0]                port_pin_in,
  input  wire logic                       address_latch_strobe,
  input  wire logic [23:0][1:0]           cfg_imc_mode,
  input  wire logic [23:0]                cfg_imc_strobe,
  input  wire logic [2:0]                 pt_imc_lo,
  input  wire logic [2:0]                 pt_imc_hi,
  // Results
  output logic      [15:0]                cell_pin_out,
  output logic      [15:0]                cell_pin_oe,
  output logic      [15:0]                cell_feedback,
  output logic      [23:0]                imc_logic_bus
);

  ////////////////////////////////////////////////////////////////////////////////
  // Elaboration check: donor wiring and limits assume groups of eight
  if (GROUP_CELLS != CMA_GROUP_CELLS)
  begin : g_bad_size
    $error("GROUP_CELLS must be 8");
  end

  ////////////////////////////////////////////////////////////////////////////////
  // State
  logic [7:0]  mask_ab_ff, mask_bc_ff;     // Host write masks
  logic        wr_prev_ff;                 // Strobe seen active last cycle
  logic [7:0]  wdata_ff;                   // Data captured while strobe active
  logic [2:0]  wtarget_ff;                 // Target captured while strobe active
  logic [7:0]  host_rdata_ff;              // Read buffer
  logic [15:0] cell_q_ff;                  // Output cell flip-flops
  logic [15:0] clk_prev_ff;                // Previous selected cell clock
  logic [15:0] pin_out_ff, pin_oe_ff, fb_ff;
  logic [23:0] imc_q_ff;                   // Input cell storage
  logic [23:0] imc_en_prev_ff;             // Previous input cell enable

  ////////////////////////////////////////////////////////////////////////////////
  // Host strobe decode
  wire        wr_act    = ~host_wr_b;
  wire        rd_act    = ~host_rd_b;
  wire        trailing  = wr_prev_ff & ~wr_act;
  wire        load_go   = cfg_level_load ? wr_act : trailing;       // RULE10
  wire [7:0]  ld_data   = cfg_level_load ? host_wdata : wdata_ff;
  wire [2:0]  ld_target = cfg_level_load ? host_target : wtarget_ff;
  wire        ld_ab     = load_go && (ld_target == 3'(CMA_TGT_CELLS_AB));
  wire        ld_bc     = load_go && (ld_target == 3'(CMA_TGT_CELLS_BC));
  wire [15:0] cell_load = {{8{ld_bc}} & ~mask_bc_ff, {8{ld_ab}} & ~mask_ab_ff}; // RULE1 RULE11

  // Read multiplexer, named targets only; anything else reads zero
  wire [7:0] rd_mux =
    (host_target == 3'(CMA_TGT_CELLS_AB)) ? cell_q_ff[7:0] :             // RULE22
    (host_target == 3'(CMA_TGT_CELLS_BC)) ? cell_q_ff[15:8] :
    (host_target == 3'(CMA_TGT_MASK_AB))  ? mask_ab_ff :
    (host_target == 3'(CMA_TGT_MASK_BC))  ? mask_bc_ff :
    (host_target == 3'(CMA_TGT_IMC_A))    ? imc_q_ff[7:0] :              // RULE19 RULE21
    (host_target == 3'(CMA_TGT_IMC_B))    ? imc_q_ff[15:8] :
    (host_target == 3'(CMA_TGT_IMC_C))    ? imc_q_ff[23:16] : CMA_DATA_RESET;

  ////////////////////////////////////////////////////////////////////////////////
  // Host capture, masks and read buffer
  // Masks always take the trailing edge so a level write cannot glitch them
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      mask_ab_ff    <= CMA_MASK_RESET;                                  // RULE12
      mask_bc_ff    <= CMA_MASK_RESET;                                  // RULE12
      wr_prev_ff    <= 1'b0;
      wdata_ff      <= CMA_DATA_RESET;
      wtarget_ff    <= 3'h0;
      host_rdata_ff <= CMA_DATA_RESET;
    end
    else
    begin
      wr_prev_ff    <= wr_act;
      host_rdata_ff <= rd_act ? rd_mux : CMA_DATA_RESET;
      if (wr_act)
      begin
        wdata_ff   <= host_wdata;
        wtarget_ff <= host_target;
      end
      if (trailing && wtarget_ff == 3'(CMA_TGT_MASK_AB))
        mask_ab_ff <= wdata_ff;
      if (trailing && wtarget_ff == 3'(CMA_TGT_MASK_BC))
        mask_bc_ff <= wdata_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Product-term allocator
  // A donor lends to its lower neighbour first; the upper one only gets
  // terms that neither the donor nor the lower neighbour holds.
  logic [15:0][3:0] pt_free, grant_up, grant_dn;
  logic [15:0]      pt_sum, sum_pol, clk_sel, clk_rise, cell_mux;

  for (genvar i = 0; i < 16; i++)
  begin : g_alloc
    localparam int G  = i / 8;
    localparam int C  = i % 8;
    localparam int RD = G * 8 + (C + 1) % 8;   // Donor above
    localparam int LD = G * 8 + (C + 7) % 8;   // Donor below
    localparam int LL = G * 8 + (C + 6) % 8;   // Lower neighbour of that donor
    localparam logic [3:0] NAT = (G == 0) ? CMA_NATIVE_AB : CMA_NATIVE_BC;   // RULE2 RULE3
    localparam logic [7:0] LIM = (G == 0) ? CMA_BORROW_AB :
                                 (C < 4) ? CMA_BORROW_BC_LO : CMA_BORROW_BC_HI; // RULE2 RULE3

    assign pt_free[i]  = ~cfg_pt_own[i] & NAT;
    assign grant_up[i] = cfg_pt_borrow[i][3:0] & LIM[3:0] & pt_free[RD];                // RULE4
    assign grant_dn[i] = cfg_pt_borrow[i][7:4] & LIM[7:4] & pt_free[LD] & ~grant_up[LL]; // RULE4
    assign pt_sum[i]   = |(pt_term[i] & cfg_pt_own[i] & NAT) |
                         |(grant_up[i] & pt_term[RD]) | |(grant_dn[i] & pt_term[LD]);
    assign sum_pol[i]  = pt_sum[i] ^ cfg_invert[i];                                      // RULE5
    assign clk_sel[i]  = cfg_ext_clk[i] ? external_clock_input : pt_clk[i];            // RULE7
    assign clk_rise[i] = clk_sel[i] & ~clk_prev_ff[i];                                   // RULE7
    assign cell_mux[i] = cfg_comb[i] ? sum_pol[i] : cell_q_ff[i];                        // RULE5
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Output cell flip-flops and pin drivers
  logic [15:0] ff_next;

  always_comb
  begin
    for (int i = 0; i < 16; i++)
    begin
      case (cma_ff_e'(cfg_ff_type[i]))                                   // RULE6
        CMA_FF_D:  ff_next[i] = sum_pol[i];
        CMA_FF_T:  ff_next[i] = cell_q_ff[i] ^ sum_pol[i];
        CMA_FF_JK: ff_next[i] = (sum_pol[i] & ~cell_q_ff[i]) | (~pt_aux[i] & cell_q_ff[i]);
        default:   ff_next[i] = sum_pol[i] | (~pt_aux[i] & cell_q_ff[i]);  // SR, set wins
      endcase
    end
  end

  // Load beats clear beats preset beats clock edge
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cell_q_ff   <= 16'h0000;
      clk_prev_ff <= 16'h0000;
      pin_out_ff  <= 16'h0000;
      pin_oe_ff   <= 16'h0000;
      fb_ff       <= 16'h0000;
    end
    else
    begin
      clk_prev_ff <= clk_sel;
      pin_out_ff  <= cell_mux;
      fb_ff       <= cell_mux;                                           // RULE15
      pin_oe_ff   <= ~cfg_internal & (pt_oe | port_dir | cfg_no_oe_eq);  // RULE13 RULE14 RULE15
      for (int i = 0; i < 16; i++)
      begin
        if (cell_load[i])
          cell_q_ff[i] <= ld_data[i % 8];                                // RULE9
        else if (pt_clear0[i] | pt_clear1[i])
          cell_q_ff[i] <= 1'b0;                                          // RULE8
        else if (pt_preset[i])
          cell_q_ff[i] <= 1'b1;                                          // RULE8
        else if (clk_rise[i])
          cell_q_ff[i] <= ff_next[i];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Input cells
  // Address-strobe enable lets the cells hold address bits above 15
  logic [23:0] imc_en;

  for (genvar j = 0; j < 24; j++)
  begin : g_imc
    wire nib_pt = (j % 8 < 4) ? pt_imc_lo[j / 8] : pt_imc_hi[j / 8];             // RULE18
    assign imc_en[j] = cfg_imc_strobe[j] ? address_latch_strobe : nib_pt;       // RULE17 RULE20
  end

  // A pass cell still costs one cycle, so all three modes share one timing
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      imc_q_ff       <= 24'h000000;
      imc_en_prev_ff <= 24'h000000;
    end
    else
    begin
      imc_en_prev_ff <= imc_en;
      for (int j = 0; j < 24; j++)
      begin
        case (cma_imc_e'(cfg_imc_mode[j]))                               // RULE16
          CMA_IMC_LATCH: if (imc_en[j]) imc_q_ff[j] <= port_pin_in[j];
          CMA_IMC_REG:   if (imc_en[j] && !imc_en_prev_ff[j]) imc_q_ff[j] <= port_pin_in[j];
          default:       imc_q_ff[j] <= port_pin_in[j];
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign host_rdata    = host_rdata_ff;
  assign cell_pin_out  = pin_out_ff;
  assign cell_pin_oe   = pin_oe_ff;
  assign cell_feedback = fb_ff;
  assign imc_logic_bus = imc_q_ff;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  sequence s_edge_write;
    (!cfg_level_load && wr_act) ##1 !wr_act;
  endsequence

  chk_mask_reset_zero: assert property ($rose(rst_b) |-> (mask_ab_ff == 8'h00) && (mask_bc_ff == 8'h00)) // RULE12
    else $error("mask not zero after reset");
  chk_trailing_edge_load: assert property (s_edge_write |-> load_go) // RULE10
    else $error("edge mode missed trailing edge load");
  chk_no_load_mid_strobe: assert property ((!cfg_level_load && wr_act) |-> !load_go) // RULE10
    else $error("edge mode loaded during strobe");
  chk_read_group_ab: assert property ((rd_act && host_target == 3'(CMA_TGT_CELLS_AB)) // RULE22
    |=> host_rdata == $past(cell_q_ff[7:0])) else $error("group read mismatch");

  for (genvar k = 0; k < 16; k++)
  begin : g_chk
    chk_load_overrides: assert property (cell_load[k] |=> cell_q_ff[k] == $past(ld_data[k % 8])) // RULE9
      else $error("host load lost");
    chk_mask_blocks: assert property ((load_go && ((k < 8) ? (ld_target == 3'(CMA_TGT_CELLS_AB) && mask_ab_ff[k % 8]) // RULE11
      : (ld_target == 3'(CMA_TGT_CELLS_BC) && mask_bc_ff[k % 8]))) |-> !cell_load[k]) else $error("masked cell loaded");
    chk_clear_wins: assert property ((!cell_load[k] && (pt_clear0[k] || pt_clear1[k])) |=> !cell_q_ff[k]) // RULE8
      else $error("clear ignored");
    chk_toggle_type: assert property ((!cell_load[k] && !pt_clear0[k] && !pt_clear1[k] && !pt_preset[k] && clk_rise[k] // RULE6
      && cfg_ff_type[k] == 2'(CMA_FF_T) && sum_pol[k]) |=> cell_q_ff[k] != $past(cell_q_ff[k])) else $error("T failed");
    chk_internal_quiet: assert property (cfg_internal[k] |=> !pin_oe_ff[k]) // RULE15
      else $error("internal node drove pin");
    chk_dir_enables: assert property ((!cfg_internal[k] && port_dir[k]) |=> pin_oe_ff[k]) // RULE13
      else $error("direction bit did not enable pin");
    chk_borrow_exclusive: assert property ((grant_up[(k / 8) * 8 + (k % 8 + 7) % 8] & grant_dn[(k / 8) * 8 + (k % 8 + 1) % 8] // RULE4
      | (grant_up[(k / 8) * 8 + (k % 8 + 7) % 8] & cfg_pt_own[k])) == 4'h0) else $error("term granted twice");
  end

endmodule

/* File: cma_host_model.sv */
// Host microcontroller model on the decoded write/read strobes.
// Assumes one bench clock; every change lands on its falling edge.
`timescale 1ns/100ps

module cma_host_model
(
  // Clock
  input  wire logic       clk,
  // Host bus
  output logic            host_wr_b,
  output logic            host_rd_b,
  output logic [2:0]      host_target,
  output logic [7:0]      host_wdata,
  input  wire logic [7:0] host_rdata
);
  ////////////////////////////////////////////////////////////////////////////////
  // Idle bus at time zero
  initial
  begin
    host_wr_b   = 1'b1;
    host_rd_b   = 1'b1;
    host_target = 3'h7;
    host_wdata  = 8'h00;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Mailbox write: strobe low one cycle, data held through the loading edge
  task automatic wr(input logic [2:0] tgt, input logic [7:0] d);
    @(negedge clk);
    host_target = tgt;
    host_wdata  = d;
    host_wr_b   = 1'b0;
    @(negedge clk);
    host_wr_b   = 1'b1;  // Trailing edge, load follows at next rise
    @(negedge clk);
    host_wdata  = ~d;    // Released bus must not keep the stale value
  endtask

  // Read: strobe held over two rising edges so the registered answer is settled
  task automatic rd(input logic [2:0] tgt, output logic [7:0] d);
    @(negedge clk);
    host_target = tgt;
    host_rd_b   = 1'b0;
    repeat (2) @(negedge clk);
    d           = host_rdata;
    host_rd_b   = 1'b1;
  endtask
endmodule

/* File: cma_macrocell_array_test.sv */
// Self-checking bench for the macrocell array: host loads, masks, clocks, pins, input cells.
// Assumes the host model drives the bus; all other inputs change at falling edges.
`timescale 1ns/100ps

module cma_macrocell_array_test;
  import cma_pkg::*;
  // Clock, reset and counters
  logic clk, rst_b;
  int   err_total, comparisons;
  // Host bus
  logic host_wr_b, host_rd_b;
  logic [2:0] host_target;
  logic [7:0] host_wdata, host_rdata;
  // Cell configuration and product terms
  logic cfg_level_load, external_clock_input, address_latch_strobe;
  logic [15:0][1:0] cfg_ff_type;
  logic [15:0][3:0] cfg_pt_own, pt_term;
  logic [15:0][7:0] cfg_pt_borrow;
  logic [15:0] cfg_invert, cfg_comb, cfg_ext_clk, cfg_internal, cfg_no_oe_eq;
  logic [15:0] pt_aux, pt_clk, pt_preset, pt_clear0, pt_clear1, pt_oe, port_dir;
  logic [15:0] cell_pin_out, cell_pin_oe, cell_feedback;
  // Input cells
  logic [23:0] port_pin_in, cfg_imc_strobe, imc_logic_bus;
  logic [23:0][1:0] cfg_imc_mode;
  logic [2:0] pt_imc_lo, pt_imc_hi;

  ////////////////////////////////////////////////////////////////////////////////
  // Design and host
  cma_macrocell_array dut_u (.clk(clk), .rst_b(rst_b), .host_wr_b(host_wr_b), .host_rd_b(host_rd_b),
    .host_target(host_target), .host_wdata(host_wdata), .host_rdata(host_rdata),
    .cfg_level_load(cfg_level_load), .cfg_ff_type(cfg_ff_type), .cfg_invert(cfg_invert),
    .cfg_comb(cfg_comb), .cfg_ext_clk(cfg_ext_clk), .cfg_internal(cfg_internal),
    .cfg_no_oe_eq(cfg_no_oe_eq), .cfg_pt_own(cfg_pt_own), .cfg_pt_borrow(cfg_pt_borrow),
    .pt_term(pt_term), .pt_aux(pt_aux), .pt_clk(pt_clk), .pt_preset(pt_preset),
    .pt_clear0(pt_clear0), .pt_clear1(pt_clear1), .pt_oe(pt_oe), .port_dir(port_dir),
    .external_clock_input(external_clock_input), .port_pin_in(port_pin_in),
    .address_latch_strobe(address_latch_strobe), .cfg_imc_mode(cfg_imc_mode),
    .cfg_imc_strobe(cfg_imc_strobe), .pt_imc_lo(pt_imc_lo), .pt_imc_hi(pt_imc_hi),
    .cell_pin_out(cell_pin_out), .cell_pin_oe(cell_pin_oe), .cell_feedback(cell_feedback),
    .imc_logic_bus(imc_logic_bus));
  cma_host_model host_u (.clk(clk), .host_wr_b(host_wr_b), .host_rd_b(host_rd_b),
    .host_target(host_target), .host_wdata(host_wdata), .host_rdata(host_rdata));

  // 40 MHz clock
  always #12.5 clk = ~clk;

  ////////////////////////////////////////////////////////////////////////////////
  // Shared helpers
  task automatic check_bus(input logic [23:0] exp, input logic [23:0] act);
    comparisons++;
    if (act !== exp)
    begin
      err_total++;
      $display("[FAIL] t=%0t exp=%h act=%h", $time, exp, act);
    end
  endtask

  task automatic rd_chk(input logic [2:0] tgt, input logic [7:0] exp);
    logic [7:0] d;
    host_u.rd(tgt, d);
    check_bus({16'h0, exp}, {16'h0, d});
  endtask

  task automatic summarize();
    $display("comparisons=%0d err_total=%0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic test_reset();
    rd_chk(CMA_TGT_MASK_AB, CMA_MASK_RESET);
    rd_chk(CMA_TGT_MASK_BC, CMA_MASK_RESET);
    rd_chk(3'h7, 8'h00);
    $display("test_reset done");
  endtask

  // Edge load into group AB, level load into group BC, then pins and feedback
  task automatic test_load();
    host_u.wr(CMA_TGT_CELLS_AB, 8'ha5);
    rd_chk(CMA_TGT_CELLS_AB, 8'ha5);
    cfg_level_load = 1'b1;
    host_u.wr(CMA_TGT_CELLS_BC, 8'h3c);
    rd_chk(CMA_TGT_CELLS_BC, 8'h3c);
    cfg_level_load = 1'b0;
    repeat (3) @(negedge clk);
    check_bus({8'h0, 8'h3c, 8'ha5}, {8'h0, cell_pin_out});
    check_bus({8'h0, 8'h3c, 8'ha5}, {8'h0, cell_feedback});
    $display("test_load done");
  endtask

  // Masked nibble keeps its old value
  task automatic test_mask();
    host_u.wr(CMA_TGT_MASK_AB, 8'h0f);
    rd_chk(CMA_TGT_MASK_AB, 8'h0f);
    host_u.wr(CMA_TGT_CELLS_AB, 8'h5a);
    rd_chk(CMA_TGT_CELLS_AB, (8'ha5 & 8'h0f) | (8'h5a & ~8'h0f));
    host_u.wr(CMA_TGT_MASK_AB, 8'h00);
    $display("test_mask done");
  endtask

  // D, inverted D, T and JK cells on term clocks, one D cell on the external clock
  task automatic test_clocked();
    host_u.wr(CMA_TGT_CELLS_AB, 8'h02);
    cfg_pt_own[0] = 4'h1; cfg_pt_own[1] = 4'h1; cfg_pt_own[2] = 4'h1;
    cfg_pt_own[6] = 4'h1; cfg_pt_own[7] = 4'h1;
    pt_term[0] = 4'h1; pt_term[1] = 4'h1; pt_term[2] = 4'h1; pt_term[6] = 4'h1; pt_term[7] = 4'h1;
    cfg_invert[1] = 1'b1;
    cfg_ext_clk[2] = 1'b1;
    cfg_ff_type[6] = CMA_FF_T;
    cfg_ff_type[7] = CMA_FF_JK;
    pt_aux[7] = 1'b1;                 // J and K both high: toggle
    @(negedge clk);
    pt_clk[7:0] = 8'hc3;              // Rising term clocks
    external_clock_input = 1'b1;      // Rising external clock
    @(negedge clk);
    pt_clk[7:0] = 8'h00;
    external_clock_input = 1'b0;
    rd_chk(CMA_TGT_CELLS_AB, 8'hc5);
    pt_clear1[0] = 1'b1;              // Second clear term alone
    pt_preset[3] = 1'b1;
    @(negedge clk);
    pt_clear1[0] = 1'b0;
    pt_preset[3] = 1'b0;
    rd_chk(CMA_TGT_CELLS_AB, 8'hcc);
    $display("test_clocked done");
  endtask

  // Pin enables from term, direction bit, no-equation outputs and internal nodes
  task automatic test_oe();
    port_dir     = 16'h000f;
    pt_oe        = 16'h00f0;
    cfg_no_oe_eq = 16'h0f00;
    cfg_internal = 16'h0101;
    repeat (3) @(negedge clk);
    check_bus({8'h0, 16'h0efe}, {8'h0, cell_pin_oe});
    check_bus({8'h0, 8'h3c, 8'hcc}, {8'h0, cell_feedback});
    $display("test_oe done");
  endtask

  // Pass, then strobe-clocked register, then term-clocked low nibble of port A
  task automatic test_imc();
    cfg_imc_mode = {24{2'h2}};
    port_pin_in  = 24'h963ca5;
    repeat (3) @(negedge clk);
    check_bus(24'h963ca5, imc_logic_bus);
    rd_chk(CMA_TGT_IMC_A, 8'ha5);
    rd_chk(CMA_TGT_IMC_C, 8'h96);
    cfg_imc_mode   = {24{2'h1}};
    cfg_imc_strobe = 24'hffffff;
    port_pin_in    = 24'h123456;
    repeat (3) @(negedge clk);
    check_bus(24'h963ca5, imc_logic_bus);
    address_latch_strobe = 1'b1;
    @(negedge clk);
    address_latch_strobe = 1'b0;
    repeat (2) @(negedge clk);
    check_bus(24'h123456, imc_logic_bus);
    cfg_imc_strobe = 24'h000000;
    port_pin_in    = 24'hfedcba;
    @(negedge clk);
    pt_imc_lo = 3'h1;
    @(negedge clk);
    pt_imc_lo = 3'h0;
    repeat (2) @(negedge clk);
    check_bus(24'h12345a, imc_logic_bus);
    $display("test_imc done");
  endtask

  // Load beats a clear pulse, then combinational cells on granted and refused terms
  task automatic test_alloc();
    fork
      host_u.wr(CMA_TGT_CELLS_AB, 8'h08);
      begin
        repeat (2) @(negedge clk);
        pt_clear0[3] = 1'b1;              // Clear term high at the loading edge
        @(negedge clk);
        pt_clear0[3] = 1'b0;
      end
    join
    rd_chk(CMA_TGT_CELLS_AB, 8'h08);
    cfg_pt_own[7]     = 4'h0;
    pt_term[6]        = 4'h3;         // Second term of cell 6 is free and high
    cfg_pt_borrow[5]  = 8'h02;        // Cell 5 takes it from above
    cfg_pt_borrow[7]  = 8'h20;        // Cell 7 asks for the same term: refused
    cfg_pt_borrow[8]  = 8'h20;        // Beyond the borrow limit of cell BC0
    cfg_pt_borrow[14] = 8'h20;        // Within the borrow limit of cell BC6
    pt_term[13]       = 4'h2;
    pt_term[15]       = 4'h2;
    cfg_invert[4]     = 1'b1;         // Empty sum inverted to one
    cfg_comb          = 16'h41b0;
    repeat (2) @(negedge clk);
    check_bus({8'h0, 16'h7c38}, {8'h0, cell_pin_out});
    check_bus({8'h0, 16'h7c38}, {8'h0, cell_feedback});
    $display("test_alloc done");
  endtask

  // Set-wins SR cell on a term clock, then port C upper nibble as a latch
  task automatic test_modes();
    cfg_ff_type[1] = CMA_FF_SR;
    cfg_invert[1]  = 1'b0;            // Set term high
    pt_aux[1]      = 1'b1;            // Reset term high as well
    @(negedge clk);
    pt_clk[1] = 1'b1;
    @(negedge clk);
    pt_clk[1] = 1'b0;
    rd_chk(CMA_TGT_CELLS_AB, 8'h0a);
    cfg_imc_mode = '0;                // All input cells transparent latches
    pt_imc_hi    = 3'h4;              // Port C bits 7:4 open
    @(negedge clk);
    port_pin_in  = 24'h0edcba;        // Open latch follows the pins
    repeat (2) @(negedge clk);
    check_bus(24'h02345a, imc_logic_bus);
    pt_imc_hi    = 3'h0;
    port_pin_in  = 24'hffffff;        // Closed latch holds
    repeat (2) @(negedge clk);
    check_bus(24'h02345a, imc_logic_bus);
    $display("test_modes done");
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence: reset for 12 cycles, then each scenario in turn
  initial
  begin
    clk = 1'b0; rst_b = 1'b0; err_total = 0; comparisons = 0;
    cfg_level_load = 1'b0; external_clock_input = 1'b0; address_latch_strobe = 1'b0;
    cfg_ff_type = '0; cfg_pt_own = '0; pt_term = '0; cfg_pt_borrow = '0;
    cfg_invert = '0; cfg_comb = '0; cfg_ext_clk = '0; cfg_internal = '0; cfg_no_oe_eq = '0;
    pt_aux = '0; pt_clk = '0; pt_preset = '0; pt_clear0 = '0; pt_clear1 = '0;
    pt_oe = '0; port_dir = '0; port_pin_in = '0; cfg_imc_strobe = '0; cfg_imc_mode = '0;
    pt_imc_lo = 3'h0; pt_imc_hi = 3'h0;
    repeat (12) @(negedge clk);
    rst_b = 1'b1;
    test_reset();
    test_load();
    test_mask();
    test_clocked();
    test_oe();
    test_imc();
    test_alloc();
    test_modes();
    summarize();
  end

  // Watchdog: scenarios need about a hundred cycles; 3000 means a hang
  initial
  begin
    repeat (3000) @(posedge clk);
    err_total++;
    summarize();
  end
endmodule
